// ### src/digest_message_builder.sv
`timescale 1ns/100ps
`include "digest_message_builder_regs.svh"

module digest_message_builder
  import dmb_pkg::*;
#(
  parameter int MSG_BYTES = `DMB_MSG_BYTES
) (
  input  wire logic         clk_sys,
  input  wire logic         reset,
  input  wire logic         cmdValid,
  input  wire cmd_s         cmd,
  output logic              cmdReady,
  input  wire temp_s        temp,
  output logic              tempWrite,
  output logic [255:0]      tempNew,
  output logic              fetchReq,
  output fetch_req_s        fetchCmd,
  input  wire logic         fetchAck,
  input  wire fetch_rsp_s   fetchRsp,
  input  wire logic [71:0]  serialNum,
  input  wire logic [87:0]  otpBytes,
  output logic              hashStart,
  output logic              hashKeyed,
  output logic [255:0]      hashKey,
  output logic [6:0]        hashLen,
  output logic              byteValid,
  output logic [7:0]        byteData,
  output logic              byteLast,
  input  wire logic         byteReady,
  input  wire logic         hashDone,
  input  wire logic [255:0] hashDigest,
  output rsp_s              rsp
);

  state_e       state_r;
  state_e       state_nxt;
  cmd_s         cmd_r;
  cmd_s         cmd_nxt;
  logic         keyed_r;
  logic         keyed_nxt;
  logic [255:0] tempVal_r;
  logic [255:0] tempVal_nxt;
  fetch_req_s   fetch_r;
  fetch_req_s   fetch_nxt;
  fetch_rsp_s   stored_r;
  fetch_rsp_s   stored_nxt;
  logic         hashStart_r;
  logic         hashStart_nxt;
  logic         tempWrite_r;
  logic         tempWrite_nxt;
  logic [255:0] tempNew_r;
  logic [255:0] tempNew_nxt;
  rsp_s         rsp_r;
  rsp_s         rsp_nxt;

  logic [MSG_BYTES*8-1:0] msgVec;
  logic [6:0]             msgLen;
  logic                   streamStart;
  logic [7:0]             mode;
  logic [63:0]            otpLow;
  logic [23:0]            otpHigh;
  logic [47:0]            serialMid;
  logic [255:0]           genHead;

  // Serial bytes are numbered from the low end of serialNum, OTP likewise
  function automatic logic [7:0] snByte(input logic [71:0] sn, input int k);
    snByte = sn[8*k +: 8];
  endfunction

  function automatic logic [7:0] otpByte(input logic [87:0] otp, input int k);
    otpByte = otp[8*k +: 8];
  endfunction

  assign mode = cmd_r.param1;

  always_comb
  begin
    otpLow    = '0;
    otpHigh   = '0;
    serialMid = '0;
    if (mode[`DMB_MODE_OTP88] || mode[`DMB_MODE_OTP64])
    begin
      for (int k = 0; k < 8; k++)
      begin
        otpLow[63-8*k -: 8] = otpByte(otpBytes, k);
      end
    end
    if (mode[`DMB_MODE_OTP88])
    begin
      for (int k = 0; k < 3; k++)
      begin
        otpHigh[23-8*k -: 8] = otpByte(otpBytes, 8 + k);
      end
    end
    if (mode[`DMB_MODE_SERIAL])
    begin
      serialMid = {snByte(serialNum, 4), snByte(serialNum, 5), snByte(serialNum, 6),
                   snByte(serialNum, 7), snByte(serialNum, 2), snByte(serialNum, 3)};
    end
  end

  // Serial bytes then zeros; the top 28 bytes give the serial and 25-zero tail of both layouts
  assign genHead = {snByte(serialNum, 8), snByte(serialNum, 0), snByte(serialNum, 1), 232'h0};

  always_comb
  begin
    msgVec = '0;
    msgLen = `DMB_GEN_LEN;
    if (keyed_r)
    begin
      msgLen = `DMB_HMAC_LEN;
      msgVec = {256'h0, tempVal_r, `DMB_OP_KEYED_HASH, mode,
                cmd_r.param2[7:0], cmd_r.param2[15:8],
                otpLow, otpHigh, snByte(serialNum, 8), serialMid[47:16],
                snByte(serialNum, 0), snByte(serialNum, 1), serialMid[15:0],
                64'h0};
    end
    else if (fetch_r.zone == `DMB_ZONE_DATA && !fetch_r.transport && stored_r.verifyOnlyFlag)
    begin
      msgVec = {stored_r.data, cmd_r.extraInputBytes, genHead[255:32], tempVal_r};
    end
    else
    begin
      msgVec = {stored_r.data, cmd_r.opcode, cmd_r.param1,
                cmd_r.param2[7:0], cmd_r.param2[15:8], genHead[255:32], tempVal_r};
    end
  end

  always_comb
  begin
    state_nxt     = state_r;
    cmd_nxt       = cmd_r;
    keyed_nxt     = keyed_r;
    tempVal_nxt   = tempVal_r;
    fetch_nxt     = fetch_r;
    stored_nxt    = stored_r;
    hashStart_nxt = 1'b0;
    tempWrite_nxt = 1'b0;
    tempNew_nxt   = tempNew_r;
    rsp_nxt       = rsp_r;
    rsp_nxt.valid = 1'b0;
    streamStart   = 1'b0;
    unique case (state_r)
      ST_IDLE:
      begin
        if (cmdValid)
        begin
          cmd_nxt            = cmd;
          tempVal_nxt        = temp.digest;
          rsp_nxt.len        = `DMB_RSP_STATUS_LEN;
          fetch_nxt.keySelector = cmd.param2;
          fetch_nxt.zone     = cmd.param1;
          fetch_nxt.slot     = cmd.param2[3:0];
          fetch_nxt.transport = 1'b0;
          state_nxt          = ST_RESPOND;
          if (cmd.opcode == `DMB_OP_KEYED_HASH)
          begin
            keyed_nxt      = 1'b1;
            fetch_nxt.zone = `DMB_ZONE_DATA;
            if ((cmd.param1 & `DMB_MODE_MBZ_MASK) != 8'h00)
              rsp_nxt.status = `DMB_ST_PARSE_ERR;
            else if (cmd.param1[`DMB_MODE_SOURCE] != temp.sourceMarker)
              rsp_nxt.status = `DMB_ST_EXEC_ERR;
            else if (!temp.valid)
              rsp_nxt.status = `DMB_ST_EXEC_ERR;
            else
              state_nxt = ST_FETCH;
          end
          else if (cmd.opcode == `DMB_OP_DIGEST_GEN)
          begin
            keyed_nxt = 1'b0;
            fetch_nxt.transport = (cmd.param1 == `DMB_ZONE_DATA) &&
                                  (cmd.param2 >= `DMB_TRANSPORT_BASE);
            if (cmd.param1 > `DMB_ZONE_DATA)
              rsp_nxt.status = `DMB_ST_PARSE_ERR;
            else if (!temp.valid)
              rsp_nxt.status = `DMB_ST_EXEC_ERR;
            else
              state_nxt = ST_FETCH;
          end
          else
          begin
            rsp_nxt.status = `DMB_ST_PARSE_ERR;
          end
        end
      end
      ST_FETCH:
      begin
        if (fetchAck)
        begin
          stored_nxt    = fetchRsp;
          hashStart_nxt = 1'b1;
          state_nxt     = ST_STREAM;
        end
      end
      ST_STREAM:
      begin
        // In the cycle hashStart is high the message is loaded into the streamer
        streamStart = 1'b1;
        state_nxt   = ST_HASH_WAIT;
      end
      ST_HASH_WAIT:
      begin
        if (hashDone)
        begin
          rsp_nxt.status = `DMB_ST_OK;
          if (keyed_r)
          begin
            rsp_nxt.len    = `DMB_RSP_DIGEST_LEN;
            rsp_nxt.digest = hashDigest;
          end
          else
          begin
            rsp_nxt.len   = `DMB_RSP_STATUS_LEN;
            tempWrite_nxt = 1'b1;
            tempNew_nxt   = hashDigest;
          end
          state_nxt = ST_RESPOND;
        end
      end
      ST_RESPOND:
      begin
        rsp_nxt.valid = 1'b1;
        state_nxt     = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      state_r     <= ST_IDLE;
      cmd_r       <= '0;
      keyed_r     <= 1'b0;
      tempVal_r   <= '0;
      fetch_r     <= '0;
      stored_r    <= '0;
      hashStart_r <= 1'b0;
      tempWrite_r <= 1'b0;
      tempNew_r   <= '0;
      rsp_r       <= '0;
    end
    else
    begin
      state_r     <= state_nxt;
      cmd_r       <= cmd_nxt;
      keyed_r     <= keyed_nxt;
      tempVal_r   <= tempVal_nxt;
      fetch_r     <= fetch_nxt;
      stored_r    <= stored_nxt;
      hashStart_r <= hashStart_nxt;
      tempWrite_r <= tempWrite_nxt;
      tempNew_r   <= tempNew_nxt;
      rsp_r       <= rsp_nxt;
    end
  end

  msg_byte_streamer #(
    .MSG_BYTES (MSG_BYTES)
  ) u_msg_byte_streamer (
    .clk_sys   (clk_sys),
    .reset     (reset),
    .start     (streamStart),
    .msg       (msgVec),
    .len       (msgLen),
    .byteValid (byteValid),
    .byteData  (byteData),
    .byteLast  (byteLast),
    .byteReady (byteReady),
    .done      ()
  );

  assign cmdReady  = (state_r == ST_IDLE);
  assign fetchReq  = (state_r == ST_FETCH);
  assign fetchCmd  = fetch_r;
  assign hashStart = hashStart_r;
  assign hashKeyed = keyed_r;
  // Key is the slot value for keyed-hash; zero for a plain hash
  assign hashKey   = keyed_r ? stored_r.data : 256'h0;
  assign hashLen   = msgLen;
  assign tempWrite = tempWrite_r;
  assign tempNew   = tempNew_r;
  assign rsp       = rsp_r;

endmodule

// ### src/digest_message_builder_regs.svh
`ifndef DIGEST_MESSAGE_BUILDER_REGS_SVH
`define DIGEST_MESSAGE_BUILDER_REGS_SVH

// Command opcodes
`define DMB_OP_DIGEST_GEN    8'h15
`define DMB_OP_KEYED_HASH    8'h11

// Zone codes of the digest-generate command
`define DMB_ZONE_CONFIG      8'h00
`define DMB_ZONE_OTP         8'h01
`define DMB_ZONE_DATA        8'h02

// Selector values at or above this pick a fixed transport key for a data-zone digest generate
`define DMB_TRANSPORT_BASE   16'h8000

// Keyed-hash mode bit positions and must-be-zero mask
`define DMB_MODE_SERIAL      6
`define DMB_MODE_OTP64       5
`define DMB_MODE_OTP88       4
`define DMB_MODE_SOURCE      2
`define DMB_MODE_MBZ_MASK    8'h8B

// Status byte values
`define DMB_ST_OK            8'h00
`define DMB_ST_PARSE_ERR     8'h03
`define DMB_ST_EXEC_ERR      8'h0F

// Message and response lengths in bytes
`define DMB_MSG_BYTES        96
`define DMB_GEN_LEN          7'h60
`define DMB_HMAC_LEN         7'h58
`define DMB_RSP_STATUS_LEN   6'h01
`define DMB_RSP_DIGEST_LEN   6'h20

`endif

// ### src/dmb_pkg.sv
package dmb_pkg;

  typedef struct packed {
    logic [7:0]  opcode;
    logic [7:0]  param1;
    logic [15:0] param2;
    logic [31:0] extraInputBytes;
  } cmd_s;

  typedef struct packed {
    logic         valid;
    logic         sourceMarker;
    logic [255:0] digest;
  } temp_s;

  typedef struct packed {
    logic [7:0]  zone;
    logic [3:0]  slot;
    logic        transport;
    logic [15:0] keySelector;
  } fetch_req_s;

  typedef struct packed {
    logic [255:0] data;
    logic         verifyOnlyFlag;
  } fetch_rsp_s;

  typedef struct packed {
    logic         valid;
    logic [5:0]   len;
    logic [7:0]   status;
    logic [255:0] digest;
  } rsp_s;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_FETCH,
    ST_STREAM,
    ST_HASH_WAIT,
    ST_RESPOND
  } state_e;

endpackage

// ### src/msg_byte_streamer.sv
`timescale 1ns/100ps
`include "digest_message_builder_regs.svh"

module msg_byte_streamer #(
  parameter int MSG_BYTES = `DMB_MSG_BYTES
) (
  input  wire logic                   clk_sys,
  input  wire logic                   reset,
  input  wire logic                   start,
  input  wire logic [MSG_BYTES*8-1:0] msg,
  input  wire logic [6:0]             len,
  output logic                        byteValid,
  output logic [7:0]                  byteData,
  output logic                        byteLast,
  input  wire logic                   byteReady,
  output logic                        done
);

  logic [MSG_BYTES*8-1:0] msg_r;
  logic [MSG_BYTES*8-1:0] msg_nxt;
  logic [6:0]             left_r;
  logic [6:0]             left_nxt;
  logic                   busy_r;
  logic                   busy_nxt;

  always_comb
  begin
    msg_nxt  = msg_r;
    left_nxt = left_r;
    busy_nxt = busy_r;
    done     = 1'b0;
    if (start)
    begin
      msg_nxt  = msg;
      left_nxt = len;
      busy_nxt = 1'b1;
    end
    else if (busy_r && byteReady)
    begin
      // First byte of the message sits in the top lane; shift it out
      msg_nxt  = {msg_r[MSG_BYTES*8-9:0], 8'h00};
      left_nxt = left_r - 7'h01;
      if (left_r == 7'h01)
      begin
        busy_nxt = 1'b0;
        done     = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      msg_r  <= '0;
      left_r <= '0;
      busy_r <= 1'b0;
    end
    else
    begin
      msg_r  <= msg_nxt;
      left_r <= left_nxt;
      busy_r <= busy_nxt;
    end
  end

  assign byteValid = busy_r;
  assign byteData  = msg_r[MSG_BYTES*8-1 -: 8];
  assign byteLast  = busy_r && (left_r == 7'h01);

endmodule

// ### testbench/dmb_store_model.sv
`timescale 1ns/100ps
module dmb_store_model
  import dmb_pkg::*;
(
  input  wire logic         clk_sys,
  input  wire logic         reset,
  input  wire logic         fetchReq,
  input  wire fetch_req_s   fetchCmd,
  output logic              fetchAck,
  output fetch_rsp_s        fetchRsp,
  input  wire logic         vflag,
  input  wire logic         slow,
  input  wire logic         byteValid,
  input  wire logic [7:0]   byteData,
  input  wire logic         byteLast,
  output logic              byteReady,
  input  wire logic         hashStart,
  input  wire logic         hashKeyed,
  input  wire logic [255:0] hashKey,
  output logic              hashDone,
  output logic [255:0]      hashDigest
);
  localparam logic [255:0] DIG = {32{8'h3C}};
  logic [7:0]   msgSeen [0:95];
  logic [255:0] keySeen;
  int           n;
  int           dly;
  // Released buses show the inverse so a late sample cannot pass by luck
  assign fetchRsp   = fetchAck ? {{32{8'hA5}}, vflag} : {{32{8'h5A}}, ~vflag};
  assign hashDigest = hashDone ? DIG : ~DIG;
  always @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      fetchAck  <= 1'b0;
      byteReady <= 1'b0;
      hashDone  <= 1'b0;
      n         <= 0;
      dly       <= 0;
    end
    else
    begin
      dly       <= fetchReq ? dly + 1 : 0;
      fetchAck  <= fetchReq && !fetchAck && dly >= (slow ? 3 : 0);
      byteReady <= slow ? !byteReady : 1'b1;
      hashDone  <= byteValid && byteReady && byteLast;
      if (hashStart)
      begin
        n       <= 0;
        keySeen <= hashKeyed ? hashKey : '0;
      end
      else if (byteValid && byteReady && n < 96)
      begin
        msgSeen[n] <= byteData;
        n          <= n + 1;
      end
    end
  end
endmodule

// ### testbench/digest_message_builder_checker.sv
`timescale 1ns/100ps
module digest_message_builder_checker
  import dmb_pkg::*;
(
  input wire logic         clk_sys,
  input wire logic         reset,
  input wire logic         cmdValid,
  input wire cmd_s         cmd,
  input wire logic         cmdReady,
  input wire temp_s        temp,
  input wire logic         tempWrite,
  input wire logic [255:0] tempNew,
  input wire logic         fetchReq,
  input wire fetch_req_s   fetchCmd,
  input wire logic         hashStart,
  input wire logic         hashKeyed,
  input wire logic [6:0]   hashLen,
  input wire logic         byteValid,
  input wire logic [7:0]   byteData,
  input wire logic         byteReady,
  input wire logic [255:0] hashDigest,
  input wire rsp_s         rsp
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);
  logic take;
  logic hm;
  assign take = cmdValid && cmdReady;
  assign hm   = take && cmd.opcode == 8'h11;
  property p_genOk;
    tempWrite |-> tempNew == $past(hashDigest) ##1 rsp.valid && rsp.len == 6'h01 && rsp.status == 8'h00;
  endproperty
  a_genOk: assert property (p_genOk) else $error("digest generate answer wrong");
  property p_genErr;
    take && cmd.opcode == 8'h15 && cmd.param1 <= 8'h02 && !temp.valid |-> ##2 rsp.valid && rsp.status == 8'h0F;
  endproperty
  a_genErr: assert property (p_genErr) else $error("invalid digest not refused");
  property p_srcErr;
    hm && (cmd.param1 & 8'h8B) == 8'h00 && cmd.param1[2] != temp.sourceMarker |-> ##2 rsp.valid && rsp.status == 8'h0F;
  endproperty
  a_srcErr: assert property (p_srcErr) else $error("source marker mismatch not refused");
  property p_parse;
    hm && (cmd.param1 & 8'h8B) != 8'h00 |-> ##2 rsp.valid && rsp.status == 8'h03;
  endproperty
  a_parse: assert property (p_parse) else $error("reserved mode bits not refused");
  property p_hmacRsp;
    rsp.valid && rsp.len == 6'h20 |-> rsp.status == 8'h00 && rsp.digest == $past(hashDigest, 2);
  endproperty
  a_hmacRsp: assert property (p_hmacRsp) else $error("keyed hash response wrong");
  property p_len;
    hashStart |-> hashLen == (hashKeyed ? 7'h58 : 7'h60);
  endproperty
  a_len: assert property (p_len) else $error("message length wrong");
  property p_slot;
    take |=> !fetchReq || (fetchCmd.keySelector == $past(cmd.param2) && fetchCmd.slot == $past(cmd.param2[3:0]));
  endproperty
  a_slot: assert property (p_slot) else $error("slot not from low selector bits");
  property p_trans;
    fetchReq && !hashKeyed && fetchCmd.zone == 8'h02 |-> fetchCmd.transport == (fetchCmd.keySelector >= 16'h8000);
  endproperty
  a_trans: assert property (p_trans) else $error("transport selection wrong");
  property p_hold;
    byteValid && !byteReady |=> byteValid && $stable(byteData);
  endproperty
  a_hold: assert property (p_hold) else $error("byte dropped while stalled");
  c_gen: cover property (tempWrite);
  c_hmac: cover property (rsp.valid && rsp.len == 6'h20);
  c_err: cover property (rsp.valid && rsp.status == 8'h0F);
endmodule
bind digest_message_builder digest_message_builder_checker u_digest_message_builder_checker (
  .clk_sys    (clk_sys),
  .reset      (reset),
  .cmdValid   (cmdValid),
  .cmd        (cmd),
  .cmdReady   (cmdReady),
  .temp       (temp),
  .tempWrite  (tempWrite),
  .tempNew    (tempNew),
  .fetchReq   (fetchReq),
  .fetchCmd   (fetchCmd),
  .hashStart  (hashStart),
  .hashKeyed  (hashKeyed),
  .hashLen    (hashLen),
  .byteValid  (byteValid),
  .byteData   (byteData),
  .byteReady  (byteReady),
  .hashDigest (hashDigest),
  .rsp        (rsp)
);

// ### testbench/digest_message_builder_tb.sv
`timescale 1ns/100ps
module digest_message_builder_tb;
  import dmb_pkg::*;
  logic clk_sys = 0, reset = 1, cmdValid = 0, vflag = 0, slow = 0;
  logic cmdReady, tempWrite, fetchReq, fetchAck, hashStart, hashKeyed, byteValid, byteLast, byteReady, hashDone;
  cmd_s         cmd = '0;
  temp_s        temp = {1'b1, 1'b0, {32{8'h77}}};
  fetch_req_s   fetchCmd;
  fetch_rsp_s   fetchRsp;
  rsp_s         rsp;
  logic [255:0] tempNew, hashKey, hashDigest;
  logic [6:0]   hashLen;
  logic [7:0]   byteData;
  logic [71:0]  serialNum;
  logic [87:0]  otpBytes;
  logic [7:0]   exp[$];
  logic [7:0]   modes[6] = '{8'h00, 8'h40, 8'h20, 8'h10, 8'h30, 8'h70};
  int mismatches = 0;
  int check_count = 0;
  digest_message_builder u_digest_message_builder (
    .clk_sys    (clk_sys),
    .reset      (reset),
    .cmdValid   (cmdValid),
    .cmd        (cmd),
    .cmdReady   (cmdReady),
    .temp       (temp),
    .tempWrite  (tempWrite),
    .tempNew    (tempNew),
    .fetchReq   (fetchReq),
    .fetchCmd   (fetchCmd),
    .fetchAck   (fetchAck),
    .fetchRsp   (fetchRsp),
    .serialNum  (serialNum),
    .otpBytes   (otpBytes),
    .hashStart  (hashStart),
    .hashKeyed  (hashKeyed),
    .hashKey    (hashKey),
    .hashLen    (hashLen),
    .byteValid  (byteValid),
    .byteData   (byteData),
    .byteLast   (byteLast),
    .byteReady  (byteReady),
    .hashDone   (hashDone),
    .hashDigest (hashDigest),
    .rsp        (rsp)
  );
  dmb_store_model u_dmb_store_model (
    .clk_sys    (clk_sys),
    .reset      (reset),
    .fetchReq   (fetchReq),
    .fetchCmd   (fetchCmd),
    .fetchAck   (fetchAck),
    .fetchRsp   (fetchRsp),
    .vflag      (vflag),
    .slow       (slow),
    .byteValid  (byteValid),
    .byteData   (byteData),
    .byteLast   (byteLast),
    .byteReady  (byteReady),
    .hashStart  (hashStart),
    .hashKeyed  (hashKeyed),
    .hashKey    (hashKey),
    .hashDone   (hashDone),
    .hashDigest (hashDigest)
  );
  always #5 clk_sys = ~clk_sys;
  function automatic logic [7:0] sn(input int k);
    return serialNum[8*k+:8];
  endfunction
  task automatic check(input string what, input logic [255:0] seen, input logic [255:0] expv);
    check_count++;
    if (seen !== expv)
    begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", what, expv, seen);
    end
  endtask
  task automatic run(input logic [7:0] op, p1, input logic [15:0] p2, input logic [7:0] st, input logic [5:0] ln);
    int i;
    @(posedge clk_sys);
    cmdValid <= 1'b1;
    cmd      <= {op, p1, p2, 32'h1122_3344};
    @(posedge clk_sys);
    cmdValid <= 1'b0;
    for (i = 0; i < 600 && rsp.valid !== 1'b1; i++) @(posedge clk_sys) #1;
    check("rsp valid", rsp.valid, 1'b1);
    check("status", rsp.status, st);
    check("rsp len", rsp.len, ln);
    $display("test op %h mode %h done", op, p1);
  endtask
  task automatic msg_check();
    check("msg count", u_dmb_store_model.n, exp.size());
    foreach (exp[k]) check("msg byte", u_dmb_store_model.msgSeen[k], exp[k]);
  endtask
  task automatic exp_gen(input logic [7:0] p1, input logic [15:0] p2, input logic vo);
    exp = {};
    repeat (32) exp.push_back(8'hA5);
    if (vo) exp = {exp, 8'h11, 8'h22, 8'h33, 8'h44};
    else exp = {exp, 8'h15, p1, p2[7:0], p2[15:8]};
    exp = {exp, sn(8), sn(0), sn(1)};
    repeat (25) exp.push_back(8'h00);
    repeat (32) exp.push_back(8'h77);
  endtask
  task automatic exp_hmac(input logic [7:0] m, input logic [15:0] p2);
    exp = {};
    repeat (32) exp.push_back(8'h00);
    repeat (32) exp.push_back(8'h77);
    exp = {exp, 8'h11, m, p2[7:0], p2[15:8]};
    for (int k = 0; k < 11; k++) exp.push_back((m[4] || (m[5] && k < 8)) ? otpBytes[8*k+:8] : 8'h00);
    exp.push_back(sn(8));
    for (int k = 4; k < 8; k++) exp.push_back(m[6] ? sn(k) : 8'h00);
    exp = {exp, sn(0), sn(1), m[6] ? sn(2) : 8'h00, m[6] ? sn(3) : 8'h00};
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic hmac_ok(input logic [7:0] m);
    exp_hmac(m, 16'h1239);
    run(8'h11, m, 16'h1239, 8'h00, 6'h20);
    check("digest", rsp.digest, {32{8'h3C}});
    check("hmac key", u_dmb_store_model.keySeen, {32{8'hA5}});
    msg_check();
  endtask
  initial
  begin
    for (int k = 0; k < 11; k++)
    begin
      if (k < 9) serialNum[8*k+:8] = 8'h40 + 8'(k);
      otpBytes[8*k+:8] = 8'hC0 + 8'(k);
    end
    repeat (2) @(posedge clk_sys);
    reset <= 1'b0;
    exp_gen(8'h02, 16'h0005, 1'b0);
    run(8'h15, 8'h02, 16'h0005, 8'h00, 6'h01);
    check("temp new", tempNew, {32{8'h3C}});
    msg_check();
    vflag <= 1'b1;
    exp_gen(8'h02, 16'h0003, 1'b1);
    run(8'h15, 8'h02, 16'h0003, 8'h00, 6'h01);
    msg_check();
    slow <= 1'b1;
    exp_gen(8'h02, 16'h8000, 1'b0);
    run(8'h15, 8'h02, 16'h8000, 8'h00, 6'h01);
    msg_check();
    exp_gen(8'h01, 16'h0001, 1'b0);
    run(8'h15, 8'h01, 16'h0001, 8'h00, 6'h01);
    msg_check();
    foreach (modes[i]) hmac_ok(modes[i]);
    run(8'h11, 8'h04, 16'h1239, 8'h0F, 6'h01);
    run(8'h11, 8'h80, 16'h1239, 8'h03, 6'h01);
    temp <= {1'b1, 1'b1, {32{8'h77}}};
    hmac_ok(8'h44);
    temp <= {1'b0, 1'b1, {32{8'h77}}};
    run(8'h15, 8'h02, 16'h0005, 8'h0F, 6'h01);
    report_and_stop();
  end
  initial
  begin
    #100000;
    mismatches++;
    report_and_stop();
  end
endmodule
